//--- hw/ecr_pkg.sv
package ecr_pkg;

  // ----------------------------------------------------------------------
  // cycle type codes driven on the request outputs
  // ----------------------------------------------------------------------
  localparam logic [2:0] REQ_IDLE         = 3'h0;
  localparam logic [2:0] REQ_BARRIER      = 3'h1;
  localparam logic [2:0] REQ_FETCH        = 3'h2;
  localparam logic [2:0] REQ_FETCH_MODIFY = 3'h3;
  localparam logic [2:0] REQ_READ_BLOCK   = 3'h4;
  localparam logic [2:0] REQ_WRITE_BLOCK  = 3'h5;
  localparam logic [2:0] REQ_LOAD_LOCKED  = 3'h6;
  localparam logic [2:0] REQ_STORE_COND   = 3'h7;

  // ----------------------------------------------------------------------
  // acknowledge codes returned by system logic
  // ----------------------------------------------------------------------
  localparam logic [2:0] ACK_IDLE         = 3'h0;
  localparam logic [2:0] ACK_HARD_FAULT   = 3'h1;
  localparam logic [2:0] ACK_SOFT_ERROR   = 3'h2;
  localparam logic [2:0] ACK_COND_FAILED  = 3'h3;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int         MASK_W           = 8;
  localparam logic [7:0] MASK_RST         = 8'h00;

  typedef enum logic {
    ECR_IDLE,
    ECR_BUSY
  } ecr_state_e;

endpackage

//--- hw/ecr_ack_decode.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------------
// acknowledge code decoder
// ------------------------------------------------------------------------
module ecr_ack_decode (
  input  wire logic [2:0] ack_code_i,
  output logic            ack_any_o,
  output logic            hard_fault_o,
  output logic            soft_error_o,
  output logic            cond_failed_o,
  output logic            ack_unknown_o
);

  always_comb begin
    hard_fault_o  = (ack_code_i == ecr_pkg::ACK_HARD_FAULT);
    soft_error_o  = (ack_code_i == ecr_pkg::ACK_SOFT_ERROR);
    cond_failed_o = (ack_code_i == ecr_pkg::ACK_COND_FAILED);
    ack_any_o     = (ack_code_i != ecr_pkg::ACK_IDLE);
    // remaining codes still end the cycle; they are reported as normal done
    ack_unknown_o = ack_code_i[2];
  end

endmodule

//--- hw/ecr_cycle_ctrl.sv
`timescale 1ns/100ps

// Functional notes
// - At the start of each external cycle a 3-bit cycle type is driven.
// - Codes 0-7: idle,barrier,fetch,fetch-modify,read,write,locked,cond.
// - During write cycles an 8-bit mask marks which longwords are written.
// - During other cycles the same 8-bit field carries cache miss info.

module ecr_cycle_ctrl (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // internal request side
  input  wire logic       cyc_valid_i,
  input  wire logic [2:0] cyc_type_i,
  input  wire logic [7:0] cyc_wmask_i,
  input  wire logic [7:0] cyc_miss_info_i,
  output logic            cyc_ready_o,
  output logic            cyc_done_o,
  output logic            cyc_hard_fault_o,
  output logic            cyc_soft_error_o,
  output logic            cyc_cond_failed_o,
  // external pins
  output logic [2:0]      cycle_type_request_o,
  output logic [7:0]      longword_write_mask_o,
  input  wire logic [2:0] cycle_acknowledge_code_i
);

  // ----------------------------------------------------------------------
  // internal signals
  // ----------------------------------------------------------------------
  ecr_pkg::ecr_state_e state_q;
  ecr_pkg::ecr_state_e state_d;
  logic [2:0]          req_q;
  logic [2:0]          req_d;
  logic [7:0]          mask_q;
  logic [7:0]          field_sel;
  logic                take;
  logic                busy;
  logic                release_cyc;
  logic                is_write;
  logic                ack_any;
  logic                ack_hard;
  logic                ack_soft;
  logic                ack_cfail;

  // ----------------------------------------------------------------------
  // acknowledge decode
  // ----------------------------------------------------------------------
  // codes above the named ones carry no fault; they still end the cycle
  ecr_ack_decode u_ack (
    .ack_code_i    (cycle_acknowledge_code_i),
    .ack_any_o     (ack_any),
    .hard_fault_o  (ack_hard),
    .soft_error_o  (ack_soft),
    .cond_failed_o (ack_cfail),
    .ack_unknown_o ()
  );

  // ----------------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------------
  // the idle code never opens a cycle, so it is not taken even when valid
  assign busy        = (state_q == ecr_pkg::ECR_BUSY);
  assign cyc_ready_o = (state_q == ecr_pkg::ECR_IDLE);
  assign take        = cyc_ready_o && cyc_valid_i &&
                       (cyc_type_i != ecr_pkg::REQ_IDLE);
  // an answer seen while idle belongs to no cycle and is dropped
  assign release_cyc = busy && ack_any;

  // ----------------------------------------------------------------------
  // cycle class
  // ----------------------------------------------------------------------
  always_comb begin
    is_write = 1'b0;
    case (cyc_type_i)
      ecr_pkg::REQ_WRITE_BLOCK,
      ecr_pkg::REQ_STORE_COND: begin
        is_write = 1'b1;
      end
      ecr_pkg::REQ_IDLE,
      ecr_pkg::REQ_BARRIER,
      ecr_pkg::REQ_FETCH,
      ecr_pkg::REQ_FETCH_MODIFY,
      ecr_pkg::REQ_READ_BLOCK,
      ecr_pkg::REQ_LOAD_LOCKED: begin
        is_write = 1'b0;
      end
      // unknown levels on the type fall back to the miss-info field
      default: begin
        is_write = 1'b0;
      end
    endcase
  end

  // one shared field: longword mask on writes, miss info on all else
  assign field_sel = is_write ? cyc_wmask_i : cyc_miss_info_i;

  // ----------------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------------
  // no time-out: system logic owns the end of every cycle, so a missing
  // answer stalls the requester until reset
  always_comb begin
    state_d = state_q;
    case (state_q)
      ecr_pkg::ECR_IDLE: begin
        if (take) begin
          state_d = ecr_pkg::ECR_BUSY;
        end
      end
      ecr_pkg::ECR_BUSY: begin
        if (ack_any) begin
          state_d = ecr_pkg::ECR_IDLE;
        end
      end
      default: begin
        state_d = ecr_pkg::ECR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_q <= ecr_pkg::ECR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // cycle type request pins
  // ----------------------------------------------------------------------
  // the code stays put for the whole cycle so that system logic may take
  // as many clocks as it likes to decode it
  always_comb begin
    req_d = req_q;
    if (take) begin
      req_d = cyc_type_i;
    end else if (release_cyc) begin
      req_d = ecr_pkg::REQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      req_q <= ecr_pkg::REQ_IDLE;
    end else begin
      req_q <= req_d;
    end
  end

  assign cycle_type_request_o = req_q;

  // ----------------------------------------------------------------------
  // longword mask pins
  // ----------------------------------------------------------------------
  // bit i belongs to longword i of the block; the field is cleared between
  // cycles so that a stale mask never stands beside the idle code, at the
  // cost of one more toggle per cycle on every set bit
  for (genvar i = 0; i < ecr_pkg::MASK_W; i++) begin : g_mask_bit
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        mask_q[i] <= ecr_pkg::MASK_RST[i];
      end else if (take) begin
        mask_q[i] <= field_sel[i];
      end else if (release_cyc) begin
        mask_q[i] <= ecr_pkg::MASK_RST[i];
      end
    end
  end

  assign longword_write_mask_o = mask_q;

  // ----------------------------------------------------------------------
  // completion report
  // ----------------------------------------------------------------------
  // every report is a one-cycle pulse on the clock after the answer
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cyc_done_o <= 1'b0;
    end else begin
      cyc_done_o <= release_cyc;
    end
  end

  // ----------------------------------------------------------------------
  // fault pulses
  // ----------------------------------------------------------------------
  // only the named codes raise a flag; the rest end the cycle quietly
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cyc_hard_fault_o <= 1'b0;
    end else if (release_cyc) begin
      cyc_hard_fault_o <= ack_hard;
    end else begin
      cyc_hard_fault_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cyc_soft_error_o <= 1'b0;
    end else if (release_cyc) begin
      cyc_soft_error_o <= ack_soft;
    end else begin
      cyc_soft_error_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cyc_cond_failed_o <= 1'b0;
    end else if (release_cyc) begin
      cyc_cond_failed_o <= ack_cfail;
    end else begin
      cyc_cond_failed_o <= 1'b0;
    end
  end

endmodule

//--- testbench/ecr_monitor.sv
`timescale 1ns/100ps
module ecr_monitor (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       cyc_valid_i,
  input wire logic [2:0] cyc_type_i,
  input wire logic [7:0] cyc_wmask_i,
  input wire logic [7:0] cyc_miss_info_i,
  input wire logic       cyc_ready_o,
  input wire logic       cyc_done_o,
  input wire logic [2:0] cycle_type_request_o,
  input wire logic [7:0] longword_write_mask_o,
  input wire logic [2:0] cycle_acknowledge_code_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire tk = cyc_valid_i && cyc_ready_o && cyc_type_i != 3'h0;
  wire wr = cyc_type_i[2] && cyc_type_i[0];
  wire ak = !cyc_ready_o && cycle_acknowledge_code_i != 3'h0;
  a_take_code:
    assert property (tk |=> cycle_type_request_o == $past(cyc_type_i))
      else $error("cycle code wrong");
  a_write_mask:
    assert property (tk && wr |=> longword_write_mask_o == $past(cyc_wmask_i))
      else $error("write mask wrong");
  a_miss_info:
    assert property (tk && !wr |=>
      longword_write_mask_o == $past(cyc_miss_info_i))
      else $error("miss wrong");
  a_hold_req:
    assert property (!cyc_ready_o && !ak |=> $stable(cycle_type_request_o)
      && $stable(longword_write_mask_o)) else $error("request moved");
  a_ack_release:
    assert property (ak |=> cycle_type_request_o == 3'h0 && cyc_done_o
      ##1 !cyc_done_o) else $error("no release");
  c_write: cover property (tk && wr);
  c_other: cover property (tk && !wr);
  c_ack: cover property (ak);
endmodule
bind ecr_cycle_ctrl ecr_monitor u_ecr_monitor (
  .sys_clk_i                (sys_clk_i),
  .rstn_i                   (rstn_i),
  .cyc_valid_i              (cyc_valid_i),
  .cyc_type_i               (cyc_type_i),
  .cyc_wmask_i              (cyc_wmask_i),
  .cyc_miss_info_i          (cyc_miss_info_i),
  .cyc_ready_o              (cyc_ready_o),
  .cyc_done_o               (cyc_done_o),
  .cycle_type_request_o     (cycle_type_request_o),
  .longword_write_mask_o    (longword_write_mask_o),
  .cycle_acknowledge_code_i (cycle_acknowledge_code_i)
);

//--- testbench/ecr_sys_model.sv
`timescale 1ns/100ps
module ecr_sys_model (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic [2:0] req_i,
  input wire logic [2:0] code_i,
  input wire logic [3:0] wait_i,
  output logic     [2:0] ack_o
);
  logic [3:0] cnt_q;
  // one-cycle answer: the requester drops its code on the edge it sees it
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || req_i == ecr_pkg::REQ_IDLE || ack_o != 3'h0) begin
      ack_o <= ecr_pkg::ACK_IDLE;
      cnt_q <= 4'h0;
    end else if (cnt_q == wait_i) begin
      ack_o <= code_i;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

//--- testbench/tb_ecr_cycle_ctrl.sv
`timescale 1ns/100ps
module tb_ecr_cycle_ctrl;
  logic       sys_clk_i = 0, rstn_i = 0, valid = 0, rdy, done, hf, se, cf;
  logic [2:0] typ = 0, code = 0, req, ack;
  logic [3:0] dly = 0;
  logic [7:0] mask, wm = 8'h00, mi = 8'h00;
  int         miscompares = 0, n_compared = 0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  ecr_cycle_ctrl u_ecr_cycle_ctrl (.sys_clk_i, .rstn_i, .cyc_valid_i(valid),
    .cyc_type_i(typ), .cyc_wmask_i(wm), .cyc_miss_info_i(mi),
    .cyc_ready_o(rdy), .cyc_done_o(done), .cyc_hard_fault_o(hf),
    .cyc_soft_error_o(se), .cyc_cond_failed_o(cf),
    .cycle_type_request_o(req), .longword_write_mask_o(mask),
    .cycle_acknowledge_code_i(ack));
  ecr_sys_model u_ecr_sys_model (.sys_clk_i, .rstn_i, .req_i(req),
    .code_i(code), .wait_i(dly), .ack_o(ack));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic xfer(input logic [2:0] t, c, input logic [3:0] d);
    int n = 0;
    @(posedge sys_clk_i);
    valid <= 1;
    typ <= t;
    code <= c;
    dly <= d;
    wm <= {t, ~t, 2'h1};
    mi <= {~t, t, 2'h2};
    @(posedge sys_clk_i);
    valid <= 0;
    #1;
    chk("req", {5'h00, t}, {4'h0, rdy, req});
    chk("mask", (t == 3'h5 || t == 3'h7) ? {t, ~t, 2'h1} : {~t, t, 2'h2},
      mask);
    while (done !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("end", {c == 3'h1, c == 3'h2, c == 3'h3, 5'h02},
      {hf, se, cf, req, rdy, 1'b0});
    chk("wait", {4'h0, d + 4'h2}, n[7:0]);
  endtask
  task automatic test_refuse;
    @(posedge sys_clk_i);
    valid <= 1;
    typ <= 3'h0;
    repeat (3) @(posedge sys_clk_i);
    valid <= 0;
    #1;
    chk("idle", 8'h08, {4'h0, rdy, req});
    $display("refuse done");
  endtask
  task automatic test_types;
    for (int i = 1; i < 8; i++) xfer(i[2:0], 3'h1, i[3:0]);
    $display("types done");
  endtask
  task automatic test_acks;
    xfer(3'h7, 3'h3, 4'h0);
    xfer(3'h4, 3'h2, 4'h9);
    xfer(3'h6, 3'h6, 4'h1);
    $display("acks done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1;
    test_refuse;
    test_types;
    test_acks;
    test_done;
  end
  initial begin
    #20000;
    miscompares++;
    test_done;
  end
endmodule
